// file: inc/crc_pkg.sv
/*
 * crc_pkg: constants for the comparator reference control block.
 * Rule summary, register map, field positions, reset values and
 * ladder arithmetic constants. Assumes one 200 MHz clock.
 */
// Summary of operation
// R01 - bit 15 set powers module, others kept
// R02 - bit 15 clear powers off, fields kept
// R03 - bit 6 routes level to output pin
// R04 - bit 5 selects range and step size
// R05 - bit 4 selects external or analog supply
// R06 - range one: level is tap/24 of source
// R07 - range zero: quarter source plus tap/32
// R08 - four-bit tap picks sixteen levels per range
// R09 - bits 31-16 and 14-7 read zero
// R10 - software idles one cycle after disabling
// R11 - all fields reset to zero
package crc_pkg;
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    localparam int          TAP_W         = 4;
    localparam int          LEVEL_W       = 8;
    localparam logic [3:0]  REG_CTRL_ADDR = 4'h0;
    localparam logic [3:0]  REG_STAT_ADDR = 4'h4;
    localparam int          BIT_ENABLE    = 15;
    localparam int          BIT_PIN_OE    = 6;
    localparam int          BIT_RANGE     = 5;
    localparam int          BIT_SOURCE    = 4;
    localparam int          TAP_LSB       = 0;
    localparam logic [31:0] CTRL_MASK     = 32'h0000807F;
    localparam logic [31:0] CTRL_RESET    = 32'h00000000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
    // level is a fraction of the source in 1/96ths (lcm of 24 and 32)
    localparam int          LEVEL_DEN     = 96;
    localparam logic [7:0]  STEP_HI       = 8'h04;
    localparam logic [7:0]  STEP_LO       = 8'h03;
    localparam logic [7:0]  OFFSET_LO     = 8'h18;
endpackage

// file: core/crc_ladder.sv
/*
 * crc_ladder: tap code and range to reference level, in 1/96ths
 * of the ladder supply. Purely combinational; the analog ladder
 * downstream turns the code into a voltage.
 */
`timescale 1ns/100ps
module crc_ladder #(
    parameter int TAP_W   = crc_pkg::TAP_W,
    parameter int LEVEL_W = crc_pkg::LEVEL_W
) (
    input  wire logic [TAP_W-1:0]   i_tap,      // ladder tap code
    input  wire logic               i_range,    // 1 = zero-based span
    output logic      [LEVEL_W-1:0] o_level     // level in 1/96 source
);
    logic [LEVEL_W-1:0] tap_ext;

    assign tap_ext = LEVEL_W'(i_tap);

    // every tap value is a distinct level in both spans [R08]
    always_comb
    begin
        if (i_range)
            o_level = LEVEL_W'(tap_ext * crc_pkg::STEP_HI);                          // [R06]
        else
            o_level = LEVEL_W'(crc_pkg::OFFSET_LO + tap_ext * crc_pkg::STEP_LO);     // [R07]
    end
endmodule

// file: core/crc_bus_slave.sv
/*
 * crc_bus_slave: Avalon-MM decode. Produces a one-cycle write strobe
 * and a read select; answers every access after one wait cycle.
 * Assumes a master that holds its request until waitrequest is low.
 */
`timescale 1ns/100ps
module crc_bus_slave #(
    parameter int ADDR_W = crc_pkg::ADDR_W
) (
    input  wire logic              i_ref_clk,     // clock
    input  wire logic              i_rst,         // sync reset
    input  wire logic              i_read,        // avalon read
    input  wire logic              i_write,       // avalon write
    output logic                   o_waitrequest, // avalon wait
    output logic                   o_wr_stb,      // write commit pulse
    output logic                   o_rd_stb       // read commit pulse
);
    logic ack_r;

    // one wait cycle, then ack; ack drops so back-to-back still waits
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            ack_r <= 1'b0;
        else
            ack_r <= (i_read | i_write) & ~ack_r;
    end

    assign o_waitrequest = ~ack_r;
    assign o_wr_stb      = ack_r & i_write;
    assign o_rd_stb      = ack_r & i_read;
endmodule

// file: core/crc_top.sv
/*
 * crc_top: comparator reference control. One control register sets
 * power, pin output, range, supply source and tap code; a status
 * register shows the live level code. Assumes a 200 MHz Avalon-MM
 * master and an analog ladder driven from the outputs.
 */
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module crc_top #(
    parameter int ADDR_W  = crc_pkg::ADDR_W,
    parameter int TAP_W   = crc_pkg::TAP_W,
    parameter int LEVEL_W = crc_pkg::LEVEL_W
) (
    input  wire logic               i_ref_clk,       // 200 MHz clock
    input  wire logic               i_rst,           // sync reset, high
    input  wire logic [ADDR_W-1:0]  i_address,       // byte address
    input  wire logic               i_read,          // read request
    input  wire logic               i_write,         // write request
    input  wire logic [31:0]        i_writedata,     // write data
    input  wire logic [3:0]         i_byteenable,    // byte lanes
    output logic      [31:0]        o_readdata,      // read data
    output logic                    o_waitrequest,   // stall
    output logic                    o_module_enable, // ladder powered
    output logic                    o_ref_pin_output_enable, // level to pin
    output logic                    o_ref_range_select,      // 1 = zero-based
    output logic                    o_ref_source_select,     // 1 = ext pins
    output logic      [TAP_W-1:0]   o_ladder_tap_code,       // tap code
    output logic      [LEVEL_W-1:0] o_comparator_reference_level // 1/96 code
);
    logic [31:0]        ctrl_r;
    logic [31:0]        ctrl_nxt;
    logic [31:0]        lane_mask;
    logic [31:0]        rd_nxt;
    logic [LEVEL_W-1:0] level_raw;
    logic [LEVEL_W-1:0] level_r;
    logic               wr_stb;
    logic               rd_stb;
    logic               ctrl_wr_hit;
    logic               ctrl_rd_hit;
    logic               stat_rd_hit;

    crc_bus_slave #(.ADDR_W(ADDR_W)) u_bus (
        .i_ref_clk     (i_ref_clk),
        .i_rst         (i_rst),
        .i_read        (i_read),
        .i_write       (i_write),
        .o_waitrequest (o_waitrequest),
        .o_wr_stb      (wr_stb),
        .o_rd_stb      (rd_stb)
    );

    // expand byte enables to a bit mask
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign lane_mask[8*g +: 8] = {8{i_byteenable[g]}};
        end
    endgenerate

    // merged write: only implemented bits and enabled lanes change, so
    // toggling enable leaves the other fields as stored
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_stb && i_address == crc_pkg::REG_CTRL_ADDR)
        begin
            ctrl_nxt = (ctrl_r & ~(lane_mask & crc_pkg::CTRL_MASK))
                     | (i_writedata & lane_mask & crc_pkg::CTRL_MASK);   // [R01] [R02] [R09]
        end
    end

    // control register, zero at reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            ctrl_r <= crc_pkg::CTRL_RESET;                               // [R11]
        else
            ctrl_r <= ctrl_nxt;
    end

    crc_ladder #(.TAP_W(TAP_W), .LEVEL_W(LEVEL_W)) u_ladder (
        .i_tap   (ctrl_r[crc_pkg::TAP_LSB +: TAP_W]),                   // [R08]
        .i_range (ctrl_r[crc_pkg::BIT_RANGE]),
        .o_level (level_raw)
    );

    // level code registered; forced to zero while powered off so the
    // ladder draws nothing, while the stored fields stay intact
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            level_r <= '0;
        else if (ctrl_r[crc_pkg::BIT_ENABLE])
            level_r <= level_raw;                                        // [R01] [R06] [R07]
        else
            level_r <= '0;                                               // [R02]
    end

    // read mux; unmapped addresses read zero. software may read in the
    // cycle after disabling here; the hazard is a far-side concern [R10]
    always_comb
    begin
        if (i_address == crc_pkg::REG_CTRL_ADDR)
            rd_nxt = ctrl_r & crc_pkg::CTRL_MASK;                        // [R09]
        else if (i_address == crc_pkg::REG_STAT_ADDR)
            rd_nxt = 32'(level_r);
        else
            rd_nxt = crc_pkg::UNMAPPED_DATA;
    end

    // read data come from a flop, valid at the ack edge
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_readdata <= 32'h00000000;
        else if ((i_read | i_write) && o_waitrequest)
            o_readdata <= rd_nxt;
    end

    // outputs from the stored fields; pin gated by enable, level from the level register
    assign o_module_enable         = ctrl_r[crc_pkg::BIT_ENABLE];
    assign o_ref_pin_output_enable = ctrl_r[crc_pkg::BIT_ENABLE] & ctrl_r[crc_pkg::BIT_PIN_OE]; // [R03]
    assign o_ref_range_select      = ctrl_r[crc_pkg::BIT_RANGE];     // [R04]
    assign o_ref_source_select     = ctrl_r[crc_pkg::BIT_SOURCE];    // [R05]
    assign o_ladder_tap_code       = ctrl_r[crc_pkg::TAP_LSB +: TAP_W];
    assign o_comparator_reference_level = level_r;

    // check helpers: the access that the bus slave commits in this cycle
    assign ctrl_wr_hit = wr_stb && (i_address == crc_pkg::REG_CTRL_ADDR);
    assign ctrl_rd_hit = rd_stb && (i_address == crc_pkg::REG_CTRL_ADDR);
    assign stat_rd_hit = rd_stb && (i_address == crc_pkg::REG_STAT_ADDR);

    // reset leaves everything off
    AST_RESET_ZERO: assert property (@(posedge i_ref_clk) // [R11]
        $past(i_rst) |-> ctrl_r == 32'h00000000 && !o_module_enable)
        else $error("control not zero after reset");

    // level, read data and pin are quiet once reset has been seen, so the
    // analog side never sees a stale code while the fields come up
    AST_RESET_LEVEL: assert property (@(posedge i_ref_clk) // [R11]
        $past(i_rst) |-> level_r == 8'h00 && o_readdata == 32'h00000000 && !o_ref_pin_output_enable)
        else $error("level, read data or pin not quiet after reset");

    // offset range, analog supply and the lowest tap are the power-on picks
    AST_RESET_FIELDS: assert property (@(posedge i_ref_clk) // [R11]
        $past(i_rst) |-> !o_ref_range_select && !o_ref_source_select && o_ladder_tap_code == '0)
        else $error("range, source or tap not zero after reset");

    // reserved bits never stored
    AST_RESERVED: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        (ctrl_r & ~crc_pkg::CTRL_MASK) == 32'h00000000)
        else $error("reserved control bit set");

    // reserved bits read back as zero whatever was written into them
    AST_RESERVED_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        ctrl_rd_hit |-> (o_readdata & ~crc_pkg::CTRL_MASK) == 32'h00000000)
        else $error("reserved bits read back non-zero");

    // the control read returns the stored fields; no write can land between
    // capture and answer, since read and write never share a request
    AST_CTRL_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        ctrl_rd_hit |-> o_readdata == (ctrl_r & crc_pkg::CTRL_MASK))
        else $error("control read data wrong");

    // the status word carries the level code only; the level may move one
    // cycle after capture, so only the upper bits are pinned here
    AST_STAT_UPPER: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        stat_rd_hit |-> (o_readdata >> LEVEL_W) == 32'h00000000)
        else $error("status upper bits non-zero");

    // unmapped addresses read as zero
    AST_UNMAPPED_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        rd_stb && i_address != crc_pkg::REG_CTRL_ADDR && i_address != crc_pkg::REG_STAT_ADDR
        |-> o_readdata == crc_pkg::UNMAPPED_DATA)
        else $error("unmapped address did not read zero");

    // read data stand after the answer; only the next request recaptures
    AST_RD_STANDS: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        !o_waitrequest |=> $stable(o_readdata))
        else $error("read data moved after the answer");

    // a waiting request is answered on the next cycle; the fixed access time
    // is what software counts on to space its accesses after a disable
    AST_WAIT_ONE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R10]
        (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("request not answered after one wait cycle");

    // the answer lasts one cycle, so a held request cannot commit in two cycles in a row
    AST_ACK_SINGLE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R10]
        !o_waitrequest |=> o_waitrequest)
        else $error("answer held longer than one cycle");

    // an idle cycle leaves the slave waiting for the next request
    AST_IDLE_WAIT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R10]
        !(i_read || i_write) |=> o_waitrequest)
        else $error("slave answered without a request");

    // a write commits only in the answer cycle of a write request
    AST_WR_STB: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R01]
        wr_stb |-> !o_waitrequest && i_write)
        else $error("write strobe outside a write answer");

    // setting enable through its own lane keeps the low fields; a tool that
    // powers the reference up must not disturb a tap set while it was off
    AST_EN_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R01]
        ctrl_wr_hit && i_byteenable[1] && i_writedata[crc_pkg::BIT_ENABLE] && !i_byteenable[0]
        |=> $stable(ctrl_r[6:0]))
        else $error("fields changed on enable write");

    // setting enable through its lane powers the module
    AST_EN_SET: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R01]
        ctrl_wr_hit && i_byteenable[1] && i_writedata[crc_pkg::BIT_ENABLE] |=> o_module_enable)
        else $error("enable write did not power the module");

    // clearing enable through its lane powers the module down
    AST_EN_CLR: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R02]
        ctrl_wr_hit && i_byteenable[1] && !i_writedata[crc_pkg::BIT_ENABLE] |=> !o_module_enable)
        else $error("disable write left the module powered");

    // clearing enable alone keeps the stored fields for the next power-up
    AST_OFF_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R02]
        ctrl_wr_hit && i_byteenable[1] && !i_writedata[crc_pkg::BIT_ENABLE] && !i_byteenable[0]
        |=> $stable(ctrl_r[6:0]))
        else $error("fields changed on disable write");

    // the low lane writes pin, range, source and tap together
    AST_LOW_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R03]
        ctrl_wr_hit && i_byteenable[0] |=> ctrl_r[6:0] == $past(i_writedata[6:0]))
        else $error("low lane write not stored");

    // without a control write the register holds; writes to the status or
    // unmapped addresses are dropped
    AST_HOLD: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R09]
        !ctrl_wr_hit |=> $stable(ctrl_r))
        else $error("control changed without a control write");

    // powered off gives level zero within one cycle
    AST_OFF_LEVEL: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R02]
        !ctrl_r[15] |=> level_r == 8'h00)
        else $error("level not zero while off");

    // a status read after two powered-off cycles shows a silent ladder
    AST_OFF_STAT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R02]
        stat_rd_hit && !$past(ctrl_r[crc_pkg::BIT_ENABLE]) && !$past(ctrl_r[crc_pkg::BIT_ENABLE], 2)
        |-> o_readdata == 32'h00000000)
        else $error("status shows a level while off");

    // enable output follows the stored bit
    AST_EN_OUT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R01]
        o_module_enable == ctrl_r[crc_pkg::BIT_ENABLE])
        else $error("enable output differs from stored bit");

    // pin driven only with bit 6 and enable
    AST_PIN: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R03]
        o_ref_pin_output_enable |-> ctrl_r[6] && ctrl_r[15])
        else $error("pin driven without request");

    // pin driven whenever requested while the module is powered
    AST_PIN_ON: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R03]
        ctrl_r[crc_pkg::BIT_ENABLE] && ctrl_r[crc_pkg::BIT_PIN_OE] |-> o_ref_pin_output_enable)
        else $error("pin not driven although requested");

    // a clear pin-output bit always releases the pin
    AST_PIN_OFF: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R03]
        !ctrl_r[crc_pkg::BIT_PIN_OE] |-> !o_ref_pin_output_enable)
        else $error("pin driven with its bit clear");

    // zero-based span: level is tap times four 1/96 units
    AST_HI_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R06]
        ctrl_r[15] && ctrl_r[5] |=> level_r == 8'($past(ctrl_r[3:0])) * 8'h04)
        else $error("high range level wrong");

    // zero-based span steps by source/24, that is four 1/96 units
    AST_HI_STEP: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R06]
        ctrl_r[crc_pkg::BIT_ENABLE] && ctrl_r[crc_pkg::BIT_RANGE] |=> level_r[1:0] == 2'h0)
        else $error("high range level off its step");

    // zero-based span tops out at fifteen steps, below two thirds
    AST_HI_MAX: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R04]
        ctrl_r[crc_pkg::BIT_ENABLE] && ctrl_r[crc_pkg::BIT_RANGE] |=> level_r <= 8'h3C)
        else $error("high range level above its span");

    // offset span: a quarter of the source plus tap times three units
    AST_LO_RANGE: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R07]
        ctrl_r[15] && !ctrl_r[5] |=> level_r == 8'h18 + 8'($past(ctrl_r[3:0])) * 8'h03)
        else $error("low range level wrong");

    // offset span stays between a quarter and three quarters
    AST_LO_SPAN: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R04]
        ctrl_r[crc_pkg::BIT_ENABLE] && !ctrl_r[crc_pkg::BIT_RANGE] |=> level_r >= 8'h18 && level_r <= 8'h45)
        else $error("low range level outside its span");

    // tap output follows the stored code in either span
    AST_TAP_OUT: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R08]
        o_ladder_tap_code == ctrl_r[crc_pkg::TAP_LSB +: TAP_W])
        else $error("tap output differs from stored code");

    // source and range selections reach the analog side unchanged
    AST_SRC: assert property (@(posedge i_ref_clk) disable iff (i_rst) // [R05]
        o_ref_source_select == ctrl_r[4] && o_ref_range_select == ctrl_r[5])
        else $error("source or range output mismatch");
endmodule

// file: tb/tb_crc_top.sv
/*
 * tb_crc_top: self-checking bench for the comparator reference control,
 * with a register model kept in a plain 32-bit word beside the design.
 * Assumes crc_pkg and crc_top are compiled first; the bench is the bus master.
 */
`timescale 1ns/100ps
module tb_crc_top;
    logic        i_ref_clk    = 1'b0;
    logic        i_rst        = 1'b1;
    logic [3:0]  i_address    = 4'h0;
    logic        i_read       = 1'b0;
    logic        i_write      = 1'b0;
    logic [31:0] i_writedata  = 32'h00000000;
    logic [3:0]  i_byteenable = 4'hF;
    logic [31:0] o_readdata;
    logic        o_waitrequest;
    logic        o_en;
    logic        o_pin;
    logic        o_rng;
    logic        o_src;
    logic [3:0]  o_tap;
    logic [7:0]  o_lvl;
    int          num_errors   = 0;
    int          compares     = 0;
    logic [31:0] ctrl_m       = 32'h00000000; // model of the control word

    // free-running 200 MHz clock
    always #2.5 i_ref_clk = ~i_ref_clk;

    crc_top i_crc_top (
        .i_ref_clk                    (i_ref_clk),
        .i_rst                        (i_rst),
        .i_address                    (i_address),
        .i_read                       (i_read),
        .i_write                      (i_write),
        .i_writedata                  (i_writedata),
        .i_byteenable                 (i_byteenable),
        .o_readdata                   (o_readdata),
        .o_waitrequest                (o_waitrequest),
        .o_module_enable              (o_en),
        .o_ref_pin_output_enable      (o_pin),
        .o_ref_range_select           (o_rng),
        .o_ref_source_select          (o_src),
        .o_ladder_tap_code            (o_tap),
        .o_comparator_reference_level (o_lvl)
    );

    task automatic close_out();
        $display("mismatches %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // level in 1/96 of the source; the ladder reads zero while powered off
    function automatic logic [7:0] lvl_of(input logic [31:0] c);
        if (!c[15])
            return 8'h00;
        return c[5] ? 8'(c[3:0] * 4) : 8'(24 + c[3:0] * 3);
    endfunction

    // one access; request held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int          n;
        logic [31:0] exp;
        exp = (a == crc_pkg::REG_CTRL_ADDR) ? ctrl_m :
              (a == crc_pkg::REG_STAT_ADDR) ? {24'h000000, lvl_of(ctrl_m)} : crc_pkg::UNMAPPED_DATA;
        i_address    <= a;
        i_writedata  <= d;
        i_byteenable <= be;
        i_read       <= !wr;
        i_write      <= wr;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (o_waitrequest !== 1'b0 && n < 20);
        if (o_waitrequest !== 1'b0)
        begin
            num_errors++;
            close_out();
        end
        if (!wr)
            chk(o_readdata, exp);
        if (wr && a == crc_pkg::REG_CTRL_ADDR)
            for (int b = 0; b < 4; b++)
                if (be[b])
                    ctrl_m[b*8 +: 8] = d[b*8 +: 8];
        ctrl_m = ctrl_m & crc_pkg::CTRL_MASK;
        i_read  <= 1'b0;
        i_write <= 1'b0;
        // idle edge after every access, so nothing follows a disable at once
        @(posedge i_ref_clk);
    endtask

    // outputs against the model, looked at once the level register settled
    task automatic chk_outs();
        logic [31:0] exp;
        @(posedge i_ref_clk);
        #1;
        exp = {16'h0000, lvl_of(ctrl_m), ctrl_m[3:0], ctrl_m[4], ctrl_m[5], ctrl_m[15] & ctrl_m[6], ctrl_m[15]};
        chk({16'h0000, o_lvl, o_tap, o_src, o_rng, o_pin, o_en}, exp);
        @(posedge i_ref_clk);
    endtask

    // main sequence: reset, ladder sweep, power toggle, random traffic, reset again
    initial
    begin
        void'($urandom(79322));
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        chk_outs();
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        $display("test reset done");
        for (int r = 0; r < 2; r++)
            for (int t = 0; t < 16; t++)
            begin
                bus(1'b1, 4'h0, ($urandom() & 32'hFFFF7FD0) | 32'h8000 | (r << 5) | t, 4'hF);
                chk_outs();
                bus(1'b0, 4'h0, 32'h0, 4'hF);
                bus(1'b0, 4'h4, 32'h0, 4'hF);
            end
        $display("test ladder sweep done");
        // toggling power through its own lane alone must keep the low fields
        bus(1'b1, 4'h0, 32'h00000000, 4'h2);
        chk_outs();
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        bus(1'b1, 4'h0, 32'h00008000, 4'h2);
        chk_outs();
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        $display("test power toggle done");
        for (int k = 0; k < 60; k++)
        begin
            bus(1'($urandom_range(1)), 4'($urandom_range(3) << 2), $urandom(), 4'($urandom_range(15)));
            chk_outs();
        end
        $display("test random traffic done");
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        ctrl_m = 32'h00000000;
        chk_outs();
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        $display("test second reset done");
        close_out();
    end
endmodule
